// file: logic/sps_regs.svh
// register map and constants of the serial port status flags block
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH
`define SPS_AW 12
`define SPS_OFF_STATCTL 12'h000
`define SPS_OFF_DATA 12'h004
`define SPS_OFF_IRQ_STAT 12'h008
`define SPS_OFF_IRQ_MASK 12'h00C
`define SPS_BIT_ENABLE 15
`define SPS_BIT_IDLE 13
`define SPS_BIT_ROV 6
`define SPS_BIT_TBF 1
`define SPS_BIT_RBF 0
`define SPS_STAT_MASK 16'hA043
`define SPS_IRQ_RX 0
`define SPS_IRQ_TX 1
`define SPS_IRQ_OVF 2
`define SPS_IRQ_W 3
`define SPS_RST_16 16'h0000
`define SPS_RST_32 32'h0000_0000
`define SPS_RST_IRQ 3'h0
`endif

// file: logic/sps_pkg.sv
// types of the serial port status flags block
package sps_pkg;
   typedef struct packed {
      logic module_enable;
      logic idle_stop;
      logic rx_overflow_flag;
      logic tx_buffer_full;
      logic rx_buffer_full;
   } sps_ctl_t;

   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } sps_word_t;

   typedef struct packed {
      sps_ctl_t ctl;
      logic [15:0] rx_holding_buffer;
      logic [15:0] tx_holding_buffer;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic irq;
      sps_word_t shift_out;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } sps_state_t;
endpackage

// file: logic/sps_top.sv
// status, control and buffer flags of the serial port, with apb slave
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`include "sps_regs.svh"
module sps_top (
   input wire logic REF_CLK_I,
   input wire logic RESETN_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [`SPS_AW-1:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic SHIFT_LOAD_REQ_I,
   input wire logic SHIFT_RX_DONE_I,
   input wire logic [15:0] SHIFT_RX_DATA_I,
   output logic SHIFT_TX_VALID_O,
   output logic [15:0] SHIFT_TX_DATA_O,
   output logic MODULE_ENABLE_O,
   output logic IDLE_STOP_O,
   output logic IRQ_O
);
   sps_pkg::sps_state_t st_r;
   sps_pkg::sps_state_t st_nxt;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic setup;
   logic access;
   logic wr_acc;
   logic rd_acc;
   logic hit_stat;
   logic hit_data;
   logic hit_ist;
   logic hit_imask;
   logic mapped;
   logic [15:0] stat_view;
   logic rov_clear;
   logic buf_write;
   logic buf_read;
   logic rx_overflow;
   logic rx_accept;
   logic tx_move;

   assign setup = PSEL_I & ~PENABLE_I;
   assign access = PSEL_I & PENABLE_I & st_r.pready;
   assign wr_acc = access & PWRITE_I & ~st_r.pslverr;
   assign rd_acc = access & ~PWRITE_I & ~st_r.pslverr;
   assign hit_stat = (PADDR_I == `SPS_OFF_STATCTL);
   assign hit_data = (PADDR_I == `SPS_OFF_DATA);
   assign hit_ist = (PADDR_I == `SPS_OFF_IRQ_STAT);
   assign hit_imask = (PADDR_I == `SPS_OFF_IRQ_MASK);
   assign mapped = hit_stat | hit_data | hit_ist | hit_imask;

   // ----------------------------------------------------------------
   // buffer events
   // ----------------------------------------------------------------
   assign rov_clear = wr_acc & hit_stat & ~PWDATA_I[`SPS_BIT_ROV];
   assign buf_write = wr_acc & hit_data;
   assign buf_read = rd_acc & hit_data;
   // a read in the same cycle frees the buffer for the new word
   assign rx_overflow = SHIFT_RX_DONE_I & st_r.ctl.rx_buffer_full &
                        ~buf_read;
   assign rx_accept = SHIFT_RX_DONE_I & ~rx_overflow;
   assign tx_move = SHIFT_LOAD_REQ_I & st_r.ctl.tx_buffer_full;

   always_comb begin
      stat_view = `SPS_RST_16;
      stat_view[`SPS_BIT_ENABLE] = st_r.ctl.module_enable;
      stat_view[`SPS_BIT_IDLE] = st_r.ctl.idle_stop;
      stat_view[`SPS_BIT_ROV] = st_r.ctl.rx_overflow_flag;
      stat_view[`SPS_BIT_TBF] = st_r.ctl.tx_buffer_full;
      stat_view[`SPS_BIT_RBF] = st_r.ctl.rx_buffer_full;
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.shift_out.valid = 1'b0;
      // zero wait: ready answers every setup cycle
      st_nxt.pready = setup;
      st_nxt.pslverr = setup & ~mapped;
      if (setup) begin
         st_nxt.prdata = `SPS_RST_32;
         if (hit_stat) begin
            st_nxt.prdata[15:0] = stat_view;
         end else if (hit_data) begin
            st_nxt.prdata[15:0] = st_r.rx_holding_buffer;
         end else if (hit_ist) begin
            st_nxt.prdata[`SPS_IRQ_W-1:0] = st_r.irq_stat;
         end else if (hit_imask) begin
            st_nxt.prdata[`SPS_IRQ_W-1:0] = st_r.irq_mask;
         end
      end

      if (wr_acc & hit_stat) begin
         st_nxt.ctl.module_enable = PWDATA_I[`SPS_BIT_ENABLE];
         st_nxt.ctl.idle_stop = PWDATA_I[`SPS_BIT_IDLE];
      end
      if (wr_acc & hit_imask) begin
         st_nxt.irq_mask = PWDATA_I[`SPS_IRQ_W-1:0];
      end

      // overflow flag: set wins over software clear
      if (rov_clear) begin
         st_nxt.ctl.rx_overflow_flag = 1'b0;
      end
      if (rx_overflow) begin
         st_nxt.ctl.rx_overflow_flag = 1'b1;
      end

      // receive side; overflow leaves the holding buffer alone
      if (buf_read) begin
         st_nxt.ctl.rx_buffer_full = 1'b0;
      end
      if (rx_accept) begin
         st_nxt.rx_holding_buffer = SHIFT_RX_DATA_I;
         st_nxt.ctl.rx_buffer_full = 1'b1;
      end

      // transmit side; a write in the same cycle refills the buffer
      if (tx_move) begin
         st_nxt.shift_out.valid = 1'b1;
         st_nxt.shift_out.data = st_r.tx_holding_buffer;
         st_nxt.ctl.tx_buffer_full = 1'b0;
      end
      if (buf_write) begin
         st_nxt.tx_holding_buffer = PWDATA_I[15:0];
         st_nxt.ctl.tx_buffer_full = 1'b1;
      end

      // interrupt status: write one clears, a new event wins
      if (wr_acc & hit_ist) begin
         st_nxt.irq_stat = st_r.irq_stat & ~PWDATA_I[`SPS_IRQ_W-1:0];
      end
      if (rx_accept) begin
         st_nxt.irq_stat[`SPS_IRQ_RX] = 1'b1;
      end
      if (tx_move) begin
         st_nxt.irq_stat[`SPS_IRQ_TX] = 1'b1;
      end
      if (rx_overflow) begin
         st_nxt.irq_stat[`SPS_IRQ_OVF] = 1'b1;
      end
      st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
   end

   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign PRDATA_O = st_r.prdata;
   assign PREADY_O = st_r.pready;
   assign PSLVERR_O = st_r.pslverr;
   assign SHIFT_TX_VALID_O = st_r.shift_out.valid;
   assign SHIFT_TX_DATA_O = st_r.shift_out.data;
   assign MODULE_ENABLE_O = st_r.ctl.module_enable;
   assign IDLE_STOP_O = st_r.ctl.idle_stop;
   assign IRQ_O = st_r.irq;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RESETN_I);

   sequence s_stat_setup;
      setup & ~PWRITE_I & hit_stat;
   endsequence

   property p_stat_reserved;
      s_stat_setup |=> (PRDATA_O[15:0] & ~`SPS_STAT_MASK) == 16'h0000
         && PRDATA_O[31:16] == 16'h0000;
   endproperty
   a_stat_reserved: assert property (p_stat_reserved)
      else $error("reserved status bits read nonzero");

   property p_rov_sticky;
      st_r.ctl.rx_overflow_flag && !rov_clear |=> st_r.ctl.rx_overflow_flag;
   endproperty
   a_rov_sticky: assert property (p_rov_sticky)
      else $error("overflow flag dropped without clear");

   property p_rov_set;
      SHIFT_RX_DONE_I && st_r.ctl.rx_buffer_full && !buf_read
         |=> st_r.ctl.rx_overflow_flag && st_r.irq_stat[`SPS_IRQ_OVF]
         && IRQ_O == (|(st_r.irq_stat & st_r.irq_mask));
   endproperty
   a_rov_set: assert property (p_rov_set)
      else $error("overflow not flagged");

   property p_rov_keep;
      rx_overflow |=> $stable(st_r.rx_holding_buffer)
         && st_r.ctl.rx_buffer_full;
   endproperty
   a_rov_keep: assert property (p_rov_keep)
      else $error("overflow altered receive buffer");

   property p_read_clears;
      buf_read && !SHIFT_RX_DONE_I |=> !st_r.ctl.rx_buffer_full;
   endproperty
   a_read_clears: assert property (p_read_clears)
      else $error("receive full not cleared by read");

   sequence s_tx_write;
      buf_write;
   endsequence

   property p_tx_set;
      s_tx_write |=> st_r.ctl.tx_buffer_full
         && st_r.tx_holding_buffer == $past(PWDATA_I[15:0]);
   endproperty
   a_tx_set: assert property (p_tx_set)
      else $error("transmit full not set by write");

   property p_tx_move;
      SHIFT_LOAD_REQ_I && st_r.ctl.tx_buffer_full && !buf_write
         |=> !st_r.ctl.tx_buffer_full && SHIFT_TX_VALID_O
         ##1 !SHIFT_TX_VALID_O;
   endproperty
   a_tx_move: assert property (p_tx_move)
      else $error("transmit move mishandled");

   property p_no_move_empty;
      !st_r.ctl.tx_buffer_full |=> !SHIFT_TX_VALID_O;
   endproperty
   a_no_move_empty: assert property (p_no_move_empty)
      else $error("shift load from empty buffer");
endmodule // sps_top

// file: tb/sps_shift_model.sv
// behavioural shift engine on the far side of the flag logic
`timescale 1ns/100ps
module sps_shift_model (
   input wire logic clk_i,
   input wire logic send_i,
   input wire logic [15:0] word_i,
   input wire logic pull_i,
   output logic rx_done_o,
   output logic [15:0] rx_data_o,
   output logic load_req_o
);
   initial begin
      rx_done_o = 1'b0;
      rx_data_o = 16'h0000;
      load_req_o = 1'b0;
   end
   // data line shows the inverse outside a finished word
   always_ff @(posedge clk_i) begin
      rx_done_o <= send_i;
      rx_data_o <= send_i ? word_i : ~rx_data_o;
      load_req_o <= pull_i;
   end
endmodule // sps_shift_model

// file: tb/test_serial_port_status_flags.sv
// self-checking bench of the serial port status flags block
`timescale 1ns/100ps
module test_serial_port_status_flags;
   typedef struct packed {
      logic w; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;
   } sps_row_t;
   logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, q, prdata;
   logic [15:0] word = 16'h0000, rx_data, tx_data;
   logic send = 0, pull = 0, rx_done, load_req, e;
   logic pready, pslverr, tx_valid, en, idle, irq;
   int num_errors = 0, n_tests = 0, n_tx = 0;
   sps_row_t rows [7] = '{
      '{1'b0, 12'h000, 32'h0000_0000, 32'h0000_0000, 1'b0},
      '{1'b1, 12'h000, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0},
      '{1'b0, 12'h000, 32'h0000_0000, 32'h0000_A000, 1'b0},
      '{1'b0, 12'h010, 32'h0000_0000, 32'h0000_0000, 1'b1},
      '{1'b1, 12'h010, 32'h0000_0000, 32'h0000_0000, 1'b1},
      '{1'b1, 12'h00C, 32'h0000_0007, 32'h0000_0000, 1'b0},
      '{1'b0, 12'h00C, 32'h0000_0000, 32'h0000_0007, 1'b0}};
   always #2 clk = ~clk;
   always @(posedge clk) if (tx_valid === 1'b1) n_tx <= n_tx + 1;
   sps_top sps_top_i (.REF_CLK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
      .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .SHIFT_LOAD_REQ_I(load_req),
      .SHIFT_RX_DONE_I(rx_done), .SHIFT_RX_DATA_I(rx_data),
      .SHIFT_TX_VALID_O(tx_valid), .SHIFT_TX_DATA_O(tx_data),
      .MODULE_ENABLE_O(en), .IDLE_STOP_O(idle), .IRQ_O(irq));
   sps_shift_model sps_shift_model_i (.clk_i(clk), .send_i(send),
      .word_i(word), .pull_i(pull), .rx_done_o(rx_done),
      .rx_data_o(rx_data), .load_req_o(load_req));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, x);
      n_tests++;
      if (s !== x) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, x, s);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d, output logic [31:0] r, output logic er);
      int k;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         num_errors++;
         end_sim();
      end
      r = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clk);
      chk("pready drop", 32'(pready), 32'h0000_0000);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input string nm, input logic [11:0] a,
         input logic [31:0] x);
      apb(1'b0, a, 32'h0000_0000, q, e);
      chk(nm, q, x);
   endtask
   task automatic shift(input logic s, input logic [15:0] v, input logic p);
      send <= s;
      word <= v;
      pull <= p;
      @(posedge clk);
      send <= 0;
      pull <= 0;
      repeat (3) @(posedge clk);
   endtask
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1;
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d, q, e);
         if (!rows[i].w) chk("row rdata", q, rows[i].q);
         chk("row slverr", 32'(e), 32'(rows[i].e));
      end
      chk("enable out", 32'(en), 32'h0000_0001);
      chk("idle out", 32'(idle), 32'h0000_0001);
      wr(12'h004, 32'h0000_1234);
      rd("tbf set", 12'h000, 32'h0000_A002);
      shift(1'b0, 16'h0000, 1'b1);
      chk("tx moves", n_tx, 32'h0000_0001);
      chk("tx data", 32'(tx_data), 32'h0000_1234);
      rd("tbf clear", 12'h000, 32'h0000_A000);
      shift(1'b0, 16'h0000, 1'b1);
      chk("empty load", n_tx, 32'h0000_0001);
      shift(1'b1, 16'hBEEF, 1'b0);
      rd("rbf set", 12'h000, 32'h0000_A001);
      shift(1'b1, 16'h5555, 1'b0);
      rd("ovf set", 12'h000, 32'h0000_A041);
      rd("old kept", 12'h004, 32'h0000_BEEF);
      rd("rbf clear", 12'h000, 32'h0000_A040);
      wr(12'h000, 32'h0000_A040);
      rd("ovf sticky", 12'h000, 32'h0000_A040);
      wr(12'h000, 32'h0000_A000);
      rd("ovf clear", 12'h000, 32'h0000_A000);
      chk("irq on", 32'(irq), 32'h0000_0001);
      rd("irq stat", 12'h008, 32'h0000_0007);
      wr(12'h008, 32'h0000_0007);
      repeat (2) @(posedge clk);
      chk("irq off", 32'(irq), 32'h0000_0000);
      wr(12'h00C, 32'h0000_0000);
      shift(1'b1, 16'h0001, 1'b0);
      chk("irq masked", 32'(irq), 32'h0000_0000);
      rd("irq masked stat", 12'h008, 32'h0000_0001);
      wr(12'h000, 32'h0000_2000);
      chk("enable low", 32'(en), 32'h0000_0000);
      chk("idle kept", 32'(idle), 32'h0000_0001);
      rd("enable bit", 12'h000, 32'h0000_2001);
      rst_n <= 0;
      @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      chk("reset enable", 32'(en), 32'h0000_0000);
      rd("reset stat", 12'h000, 32'h0000_0000);
      end_sim();
   end
endmodule // test_serial_port_status_flags
